/* cap_pin_model.sv */
// far side of the timer: capture pin source and compare pin monitor
// assumes the same clock as the timer; capture pin idles low
`timescale 1ns/100ps
module cap_pin_model (
    input wire logic clk_sys,
    output logic capture_in,
    input wire logic compare_out
);
    initial capture_in = 1'b0;
    task automatic pulse(input int w);
        @(posedge clk_sys);
        capture_in <= 1'b1;
        repeat (w) @(posedge clk_sys);
        capture_in <= 1'b0;
    endtask
    task automatic count_high(input int n, output int h);
        h = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if (compare_out === 1'b1) h++;
        end
    endtask
endmodule

/* gp_timer.sv */
// general-purpose 16-bit timer with one capture/compare channel
// assumes register port on clk_sys; capture_in is asynchronous
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module gp_timer
    import gp_timer_pkg::*;
#(
    parameter int FILTER_W = 4
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire bus_req_s bus_req,
    output logic [DW-1:0] rd_data,
    input wire logic capture_in,
    output logic compare_out,
    output logic update_event,
    output logic irq,
    output logic dma_req
);
    logic rst_sync_q;
    logic rst_n;
    // registers
    logic cnt_en_q;
    logic update_disable_q;
    logic [1:0] count_direction_select_q;
    logic compare_dma_select_q;
    logic [3:0] irq_dma_en_q;
    logic upd_flag_q;
    logic channel_event_flag_q;
    chan_mode_s chan_mode_q;
    logic chan_enable_q;
    logic channel_output_polarity_q;
    logic [DW-1:0] counter_value_q;
    logic [DW-1:0] counter_value_d;
    logic [DW-1:0] prescale_value_q;
    logic [DW-1:0] prescale_active_q;
    logic [DW-1:0] auto_reload_value_q;
    logic [DW-1:0] reload_active_q;
    logic [DW-1:0] channel_compare_value_q;
    logic [DW-1:0] psc_cnt_q;
    phase_e phase_q;
    phase_e phase_d;
    logic [DW-1:0] rd_data_q;
    // capture path
    logic cap_s1_q;
    logic cap_s2_q;
    logic cap_filt_q;
    logic [FILTER_W-1:0] filt_cnt_q;
    logic [2:0] cap_div_q;
    // compare path
    logic match_q;
    logic compare_reference_output_q;
    logic compare_out_q;

    logic wr_ctrl1, wr_ctrl2, wr_en, wr_sts, wr_gen, wr_mode, wr_chen;
    logic wr_cnt, wr_psc, wr_arr, wr_cc;
    logic tick, ovf, unf, soft_upd, upd, soft_ch;
    logic cap_edge, cap_evt, cap_take, match, cmp_evt, ch_evt;
    logic is_output;

    function automatic logic hit(input bus_req_s r, input logic [7:0] off);
        hit = r.wr && (r.addr == off);
    endfunction

    assign wr_ctrl1 = hit(bus_req, OFF_CTRL1);
    assign wr_ctrl2 = hit(bus_req, OFF_CTRL2);
    assign wr_en = hit(bus_req, OFF_IRQ_DMA_EN);
    assign wr_sts = hit(bus_req, OFF_STATUS);
    assign wr_gen = hit(bus_req, OFF_EVENT_GEN);
    assign wr_mode = hit(bus_req, OFF_CHAN_MODE);
    assign wr_chen = hit(bus_req, OFF_CHAN_EN);
    assign wr_cnt = hit(bus_req, OFF_COUNTER);
    assign wr_psc = hit(bus_req, OFF_PRESCALE);
    assign wr_arr = hit(bus_req, OFF_RELOAD);
    assign wr_cc = hit(bus_req, OFF_COMPARE);

    // reset release
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync_q <= 1'b1;
            rst_n <= rst_sync_q;
        end
    end

    // control registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_en_q <= 1'b0;
            update_disable_q <= 1'b0;
            count_direction_select_q <= DIR_SEL_UP;
            compare_dma_select_q <= 1'b0;
            irq_dma_en_q <= 4'h0;
            chan_mode_q <= chan_mode_s'(RST_ZERO);
            chan_enable_q <= 1'b0;
            channel_output_polarity_q <= 1'b0;
            prescale_value_q <= RST_ZERO;
            auto_reload_value_q <= RST_RELOAD;
            channel_compare_value_q <= RST_ZERO;
        end else begin
            if (wr_ctrl1) begin
                cnt_en_q <= bus_req.wdata[B_CNT_EN];
                update_disable_q <= bus_req.wdata[B_UPD_DIS]; // [R10]
                count_direction_select_q <=
                    bus_req.wdata[B_DIR_LO+1:B_DIR_LO]; // [R2]
            end
            if (wr_ctrl2) begin
                compare_dma_select_q <= bus_req.wdata[B_CC_DMA_SEL];
            end
            if (wr_en) begin
                irq_dma_en_q <= {bus_req.wdata[B_CH_DMA_EN],
                    bus_req.wdata[B_UPD_DMA_EN],
                    bus_req.wdata[B_CH_IRQ_EN],
                    bus_req.wdata[B_UPD_IRQ_EN]};
            end
            if (wr_mode) begin
                chan_mode_q <= chan_mode_s'(bus_req.wdata);
            end
            if (wr_chen) begin
                chan_enable_q <= bus_req.wdata[B_CH_ENABLE];
                channel_output_polarity_q <= bus_req.wdata[B_CH_POL];
            end
            if (wr_psc) begin
                prescale_value_q <= bus_req.wdata; // [R5]
            end
            if (wr_arr) begin
                auto_reload_value_q <= bus_req.wdata;
            end
            if (cap_take) begin
                channel_compare_value_q <= counter_value_q; // [R13]
            end else if (wr_cc) begin
                channel_compare_value_q <= bus_req.wdata;
            end
        end
    end

    assign is_output = !chan_mode_q.capture_select;
    assign soft_upd = wr_gen && bus_req.wdata[B_GEN_UPD];
    assign soft_ch = wr_gen && bus_req.wdata[B_GEN_CH];

    // prescaler on the internal timer clock [R3]
    assign tick = cnt_en_q && (psc_cnt_q == prescale_active_q); // [R21]

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            psc_cnt_q <= RST_ZERO;
        end else if (upd && soft_upd) begin
            psc_cnt_q <= RST_ZERO;
        end else if (cnt_en_q) begin
            psc_cnt_q <= tick ? RST_ZERO : psc_cnt_q + 16'h0001; // [R4]
        end
    end

    // counter next value and overflow/underflow
    always_comb begin
        counter_value_d = counter_value_q;
        phase_d = phase_q;
        ovf = 1'b0;
        unf = 1'b0;
        if (count_direction_select_q == DIR_SEL_UP) begin
            phase_d = PHASE_UP;
            if (counter_value_q >= reload_active_q) begin
                counter_value_d = RST_ZERO; // [R6]
                ovf = 1'b1;
            end else begin
                counter_value_d = counter_value_q + 16'h0001;
            end
        end else if (count_direction_select_q == DIR_SEL_DOWN) begin
            phase_d = PHASE_DOWN;
            if (counter_value_q == RST_ZERO) begin
                counter_value_d = reload_active_q; // [R7]
                unf = 1'b1;
            end else begin
                counter_value_d = counter_value_q - 16'h0001;
            end
        end else begin
            case (phase_q) // [R8]
                PHASE_UP: begin
                    ovf = (counter_value_q == reload_active_q - 16'h0001);
                    if (counter_value_q >= reload_active_q) begin
                        counter_value_d = counter_value_q - 16'h0001;
                        phase_d = PHASE_DOWN;
                    end else begin
                        counter_value_d = counter_value_q + 16'h0001;
                    end
                end
                PHASE_DOWN: begin
                    unf = (counter_value_q == 16'h0001);
                    if (counter_value_q == RST_ZERO) begin
                        counter_value_d = counter_value_q + 16'h0001;
                        phase_d = PHASE_UP;
                    end else begin
                        counter_value_d = counter_value_q - 16'h0001;
                        if (counter_value_q == 16'h0001) begin
                            phase_d = PHASE_UP;
                        end
                    end
                end
                default: begin
                    phase_d = PHASE_UP;
                end
            endcase
            if (reload_active_q == RST_ZERO) begin
                counter_value_d = RST_ZERO;
                ovf = 1'b0;
                unf = 1'b0;
            end
        end
    end

    // update event from wrap or software [R9] [R10]
    assign upd = !update_disable_q && ((tick && (ovf || unf)) || soft_upd);
    assign update_event = upd;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            counter_value_q <= RST_ZERO;
            phase_q <= PHASE_UP;
        end else if (upd && soft_upd) begin
            phase_q <= PHASE_UP;
            counter_value_q <= (count_direction_select_q == DIR_SEL_DOWN)
                ? auto_reload_value_q : RST_ZERO;
        end else if (wr_cnt) begin
            counter_value_q <= bus_req.wdata;
        end else if (tick) begin
            counter_value_q <= counter_value_d; // [R1]
            phase_q <= phase_d;
        end
    end

    // active copies loaded only at update [R5] [R9]
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prescale_active_q <= RST_ZERO;
            reload_active_q <= RST_RELOAD;
        end else if (upd) begin
            prescale_active_q <= prescale_value_q;
            reload_active_q <= auto_reload_value_q; // [R17]
        end
    end

    // capture input: sync, filter, edge, event divider [R12]
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cap_s1_q <= 1'b0;
            cap_s2_q <= 1'b0;
        end else begin
            cap_s1_q <= capture_in;
            cap_s2_q <= cap_s1_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cap_filt_q <= 1'b0;
            filt_cnt_q <= '0;
        end else if (cap_s2_q == cap_filt_q) begin
            filt_cnt_q <= '0;
        end else if (filt_cnt_q >= FILTER_W'(chan_mode_q.filter_len)) begin
            cap_filt_q <= cap_s2_q;
            filt_cnt_q <= '0;
        end else begin
            filt_cnt_q <= filt_cnt_q + FILTER_W'(1);
        end
    end

    // polarity bit picks the falling edge in capture mode
    assign cap_edge = (cap_s2_q != cap_filt_q)
        && (filt_cnt_q >= FILTER_W'(chan_mode_q.filter_len))
        && (cap_s2_q ^ channel_output_polarity_q);
    assign cap_evt = cap_edge && chan_enable_q && !is_output;
    // divider takes 1, 2, 4 or 8 qualified edges per capture [R12]
    assign cap_take = cap_evt && (((cap_div_q + 3'h1) & ((3'h1 <<
        chan_mode_q.capture_prescale) - 3'h1)) == 3'h0);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cap_div_q <= 3'h0;
        end else if (is_output || !chan_enable_q || wr_mode) begin
            cap_div_q <= 3'h0;
        end else if (cap_evt) begin
            cap_div_q <= cap_div_q + 3'h1;
        end
    end

    // output compare [R14] [R15]
    assign match = is_output && (counter_value_q == channel_compare_value_q);
    assign cmp_evt = match && !match_q; // [R20]

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            compare_reference_output_q <= 1'b0;
        end else begin
            case (chan_mode_q.output_compare_mode)
                OC_SET_MATCH: if (cmp_evt) begin
                    compare_reference_output_q <= 1'b1;
                end
                OC_CLR_MATCH: if (cmp_evt) begin
                    compare_reference_output_q <= 1'b0;
                end
                OC_TOGGLE: if (cmp_evt) begin
                    compare_reference_output_q <= !compare_reference_output_q;
                end
                OC_FORCE_LOW: compare_reference_output_q <= 1'b0; // [R20]
                OC_FORCE_HIGH: compare_reference_output_q <= 1'b1;
                OC_PWM1: compare_reference_output_q <=
                    (counter_value_d < channel_compare_value_q)
                    && tick || (counter_value_q < channel_compare_value_q)
                    && !tick; // [R18]
                OC_PWM2: compare_reference_output_q <=
                    !((counter_value_d < channel_compare_value_q)
                    && tick || (counter_value_q < channel_compare_value_q)
                    && !tick); // [R19]
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            compare_out_q <= 1'b0;
        end else begin
            compare_out_q <= chan_enable_q && is_output &&
                (compare_reference_output_q ^ channel_output_polarity_q);
        end
    end
    assign compare_out = compare_out_q;

    // status flags; hardware set wins over a write of zero
    assign ch_evt = cap_take || (chan_enable_q && cmp_evt) || soft_ch;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            upd_flag_q <= 1'b0;
            channel_event_flag_q <= 1'b0;
        end else begin
            if (upd) begin
                upd_flag_q <= 1'b1;
            end else if (wr_sts && !bus_req.wdata[B_UPD_FLAG]) begin
                upd_flag_q <= 1'b0;
            end
            if (ch_evt) begin
                channel_event_flag_q <= 1'b1; // [R13]
            end else if (wr_sts && !bus_req.wdata[B_CH_FLAG]) begin
                channel_event_flag_q <= 1'b0;
            end
        end
    end

    // requests [R11] [R16]
    assign irq = (upd_flag_q && irq_dma_en_q[0])
        || (channel_event_flag_q && irq_dma_en_q[1]);
    assign dma_req = (upd_flag_q && irq_dma_en_q[2])
        || (channel_event_flag_q && irq_dma_en_q[3] && compare_dma_select_q);

    // read port, data one cycle after strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= RST_ZERO;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                OFF_CTRL1: rd_data_q <= DW'({count_direction_select_q,
                    3'h0, update_disable_q, cnt_en_q});
                OFF_CTRL2: rd_data_q <= DW'({compare_dma_select_q, 3'h0});
                OFF_IRQ_DMA_EN: rd_data_q <= DW'({irq_dma_en_q[3:2], 6'h00,
                    irq_dma_en_q[1:0]});
                OFF_STATUS: rd_data_q <= DW'({channel_event_flag_q,
                    upd_flag_q});
                OFF_CHAN_MODE: rd_data_q <= DW'(chan_mode_q);
                OFF_CHAN_EN: rd_data_q <= DW'({channel_output_polarity_q,
                    chan_enable_q});
                OFF_COUNTER: rd_data_q <= counter_value_q;
                OFF_PRESCALE: rd_data_q <= prescale_value_q;
                OFF_RELOAD: rd_data_q <= auto_reload_value_q;
                OFF_COMPARE: rd_data_q <= channel_compare_value_q;
                default: rd_data_q <= RST_ZERO;
            endcase
        end else begin
            rd_data_q <= RST_ZERO;
        end
    end
    assign rd_data = rd_data_q;
endmodule

/* gp_timer_pkg.sv */
// constants, types and register layout of the capture/compare timer
// assumes a single system clock and a plain one-cycle register port
// Overview of operation
// [R1] sixteen-bit counter counts up, down or center-aligned
// [R2] count direction select field in control register 1 picks the mode
// [R3] prescaler input clock is the internal timer clock
// [R4] sixteen-bit prescaler divides by 1 to 65536, output advances counter
// [R5] prescale value is buffered, applied at the next update event
// [R6] up: from 0, plus one, at reload value back to 0 with overflow
// [R7] down: from reload value, minus one, at 0 reload with underflow
// [R8] center: 0 up to reload and back; overflow at reload-1, underflow at 1
// [R9] overflow or underflow makes update event loading buffered values
// [R10] update disable bit suppresses update events and buffer transfers
// [R11] interrupt or DMA requests for update, capture and compare events
// [R12] capture input: edge detector, filter, then event prescaler; the code filters first and detects the edge on the filtered input
// [R13] capture copies counter to channel register, sets flag, irq if enabled
// [R14] compare mode field selects one of eight output behaviours
// [R15] on compare match output goes high, low or toggles per mode, polarity
// [R16] channel flag gives irq if enabled, DMA if compare DMA select is 1
// [R17] PWM period from reload value, pulse width from compare value
// [R18] PWM 1: reference active while counter below compare value
// [R19] PWM 2: reference inactive while counter below compare value
// [R20] codes 100 and 101 force reference; compare events still produced
// [R21] counter advances every prescale value plus one input clocks
package gp_timer_pkg;
    localparam int DW = 16;
    localparam int AW = 8;
    // register offsets
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_IRQ_DMA_EN = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_EVENT_GEN = 8'h14;
    localparam logic [7:0] OFF_CHAN_MODE = 8'h18;
    localparam logic [7:0] OFF_CHAN_EN = 8'h20;
    localparam logic [7:0] OFF_COUNTER = 8'h24;
    localparam logic [7:0] OFF_PRESCALE = 8'h28;
    localparam logic [7:0] OFF_RELOAD = 8'h2c;
    localparam logic [7:0] OFF_COMPARE = 8'h34;
    // field positions
    localparam int B_CNT_EN = 0;
    localparam int B_UPD_DIS = 1;
    localparam int B_DIR_LO = 5;
    localparam int B_CC_DMA_SEL = 3;
    localparam int B_UPD_IRQ_EN = 0;
    localparam int B_CH_IRQ_EN = 1;
    localparam int B_UPD_DMA_EN = 8;
    localparam int B_CH_DMA_EN = 9;
    localparam int B_UPD_FLAG = 0;
    localparam int B_CH_FLAG = 1;
    localparam int B_GEN_UPD = 0;
    localparam int B_GEN_CH = 1;
    localparam int B_CH_ENABLE = 0;
    localparam int B_CH_POL = 1;
    // reset values
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_RELOAD = 16'hffff;
    // count direction select codes
    localparam logic [1:0] DIR_SEL_UP = 2'h0;
    localparam logic [1:0] DIR_SEL_DOWN = 2'h1;
    // output compare mode codes
    localparam logic [2:0] OC_FREEZE = 3'h0;
    localparam logic [2:0] OC_SET_MATCH = 3'h1;
    localparam logic [2:0] OC_CLR_MATCH = 3'h2;
    localparam logic [2:0] OC_TOGGLE = 3'h3;
    localparam logic [2:0] OC_FORCE_LOW = 3'h4;
    localparam logic [2:0] OC_FORCE_HIGH = 3'h5;
    localparam logic [2:0] OC_PWM1 = 3'h6;
    localparam logic [2:0] OC_PWM2 = 3'h7;

    typedef enum logic [1:0] {
        PHASE_UP = 2'b01,
        PHASE_DOWN = 2'b10
    } phase_e;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    // channel mode register layout
    typedef struct packed {
        logic [3:0] unused;
        logic [3:0] filter_len;
        logic unused7;
        logic [2:0] output_compare_mode;
        logic [1:0] capture_prescale;
        logic unused1;
        logic capture_select;
    } chan_mode_s;
endpackage

/* gp_timer_sva.sv */
// port assertions for gp_timer: read port, update, irq, dma, compare pin
// assumes binding to gp_timer; control registers are shadowed from writes
`timescale 1ns/100ps
module gp_timer_sva
    import gp_timer_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire bus_req_s bus_req,
    input wire logic [DW-1:0] rd_data,
    input wire logic compare_out,
    input wire logic update_event,
    input wire logic irq,
    input wire logic dma_req
);
    logic [15:0] ctrl1_q, ctrl2_q, en_q, mode_q, chen_q;
    logic forced;
    logic [5:0] fsel;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl1_q <= '0;
            ctrl2_q <= '0;
            en_q <= '0;
            mode_q <= '0;
            chen_q <= '0;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                OFF_CTRL1: ctrl1_q <= bus_req.wdata;
                OFF_CTRL2: ctrl2_q <= bus_req.wdata;
                OFF_IRQ_DMA_EN: en_q <= bus_req.wdata;
                OFF_CHAN_MODE: mode_q <= bus_req.wdata;
                OFF_CHAN_EN: chen_q <= bus_req.wdata;
                default: ;
            endcase
        end
    end
    // enabled output channel in code 100 or 101
    assign forced = chen_q[0] && !mode_q[0] && mode_q[6:5] == 2'b10;
    assign fsel = {mode_q[6:4], mode_q[0], chen_q[1:0]};
    sequence s_forced;
        (forced && $stable(fsel)) [*3];
    endsequence
    sequence s_off;
        (!chen_q[B_CH_ENABLE] || mode_q[0]) [*3];
    endsequence
    chk_rd_idle: assert property (!$past(bus_req.rd) |-> rd_data == '0)
        else $error("read data not idle");
    chk_rd_ctrl1: assert property (
        bus_req.rd && bus_req.addr == OFF_CTRL1
        |=> rd_data == ($past(ctrl1_q) & 16'h0063))
        else $error("control 1 read back wrong");
    chk_upd_off: assert property (
        ctrl1_q[B_UPD_DIS] |-> !update_event)
        else $error("update while disabled");
    chk_upd_irq: assert property (
        update_event && en_q[B_UPD_IRQ_EN] && !bus_req.wr |=> irq)
        else $error("update gave no irq");
    chk_irq_gate: assert property (
        en_q[1:0] == 2'b00 |-> !irq)
        else $error("irq while disabled");
    chk_dma_gate: assert property (
        !en_q[B_UPD_DMA_EN] && !(en_q[B_CH_DMA_EN] && ctrl2_q[3])
        |-> !dma_req)
        else $error("dma request while disabled");
    chk_off_low: assert property (s_off |-> !compare_out)
        else $error("output active while channel off");
    chk_force_lvl: assert property (
        s_forced |-> compare_out == (mode_q[4] ^ chen_q[B_CH_POL]))
        else $error("forced level wrong");
endmodule

bind gp_timer gp_timer_sva i_gp_timer_sva (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .compare_out(compare_out),
    .update_event(update_event),
    .irq(irq),
    .dma_req(dma_req)
);

/* gp_timer_tb_top.sv */
// self-checking bench for gp_timer: counting, compare modes, capture
// assumes cap_pin_model drives the capture pin and watches compare_out
`timescale 1ns/100ps
module gp_timer_tb_top;
    import gp_timer_pkg::*;
    logic clk_sys, nrst, capture_in, compare_out, update_event, irq, dma_req;
    logic [DW-1:0] rd_data;
    bus_req_s bus_req;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    gp_timer i_gp_timer (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req),
        .rd_data(rd_data), .capture_in(capture_in),
        .compare_out(compare_out), .update_event(update_event),
        .irq(irq), .dma_req(dma_req));
    cap_pin_model i_cap_pin_model (.clk_sys(clk_sys),
        .capture_in(capture_in), .compare_out(compare_out));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1 chk("read data", e, rd_data);
    endtask
    task automatic pin(input string nm, input logic e);
        @(negedge clk_sys);
        chk(nm, 16'(e), nm == "irq" ? 16'(irq) : 16'(dma_req));
    endtask
    // cycles between two update pulses, after skipping to the first
    task automatic gap(input int e);
        int n = 0;
        int k = 0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (update_event !== 1'b1 && k < 300);
        do begin
            @(negedge clk_sys);
            n++;
        end while (update_event !== 1'b1 && n < 300);
        chk("update gap", 16'(e), 16'(n));
    endtask
    task automatic hi(input int n, input int e);
        int h;
        tick(16);
        i_cap_pin_model.count_high(n, h);
        chk("high cycles", 16'(e), 16'(h));
    endtask
    task automatic t_up();
        rc(OFF_RELOAD, 16'hffff);
        rc(8'h08, 16'h0000);
        wr(OFF_PRESCALE, 16'h0002);
        wr(OFF_RELOAD, 16'h0004);
        wr(OFF_EVENT_GEN, 16'h0001);
        wr(OFF_IRQ_DMA_EN, 16'h0001);
        wr(OFF_CTRL1, 16'h0001);
        gap(15);
        wr(OFF_PRESCALE, 16'h0000);
        gap(5);
        pin("irq", 1'b1);
    endtask
    task automatic t_down();
        wr(OFF_CTRL1, 16'h0020);
        wr(OFF_EVENT_GEN, 16'h0001);
        rc(OFF_COUNTER, 16'h0004);
        wr(OFF_CTRL1, 16'h0021);
        gap(5);
    endtask
    task automatic t_center();
        wr(OFF_CTRL1, 16'h0041);
        rc(OFF_CTRL1, 16'h0041);
        gap(4);
        gap(4);
    endtask
    task automatic t_upd_dis();
        int c = 0;
        wr(OFF_CTRL1, 16'h0043);
        wr(OFF_EVENT_GEN, 16'h0001);
        repeat (40) begin
            @(negedge clk_sys);
            if (update_event === 1'b1) c++;
        end
        chk("update count", 16'h0000, 16'(c));
    endtask
    task automatic t_modes();
        logic [2:0] md[8] = '{4, 0, 1, 2, 3, 5, 6, 7};
        int ex[8] = '{0, 0, 16, 0, 8, 16, 10, 6};
        wr(OFF_CTRL1, 16'h0001);
        wr(OFF_RELOAD, 16'h0007);
        wr(OFF_EVENT_GEN, 16'h0001);
        wr(OFF_COMPARE, 16'h0005);
        wr(OFF_CHAN_EN, 16'h0001);
        foreach (md[i]) begin
            wr(OFF_CHAN_MODE, {9'h000, md[i], 4'h0});
            hi(16, ex[i]);
        end
        wr(OFF_CHAN_EN, 16'h0003);
        hi(16, 10);
        wr(OFF_CHAN_EN, 16'h0001);
        wr(OFF_CHAN_MODE, 16'h0060);
        wr(OFF_CTRL1, 16'h0041);
        hi(28, 18);
    endtask
    task automatic t_force_evt();
        wr(OFF_CHAN_MODE, 16'h0050);
        wr(OFF_IRQ_DMA_EN, 16'h0202);
        wr(OFF_STATUS, 16'h0000);
        tick(20);
        pin("irq", 1'b1);
        pin("dma", 1'b0);
        wr(OFF_CTRL2, 16'h0008);
        pin("dma", 1'b1);
        wr(OFF_CTRL2, 16'h0000);
    endtask
    task automatic t_capture();
        wr(OFF_CTRL1, 16'h0000);
        wr(OFF_CHAN_MODE, 16'h0001);
        wr(OFF_STATUS, 16'h0000);
        wr(OFF_COUNTER, 16'h0123);
        i_cap_pin_model.pulse(4);
        tick(12);
        rc(OFF_COMPARE, 16'h0123);
        pin("irq", 1'b1);
        wr(OFF_CHAN_MODE, 16'h0305);
        wr(OFF_STATUS, 16'h0000);
        wr(OFF_COUNTER, 16'h0456);
        i_cap_pin_model.pulse(1);
        i_cap_pin_model.pulse(6);
        tick(16);
        pin("irq", 1'b0);
        i_cap_pin_model.pulse(6);
        tick(16);
        rc(OFF_COMPARE, 16'h0456);
        wr(OFF_CHAN_MODE, 16'h0001);
        wr(OFF_CHAN_EN, 16'h0003);
        wr(OFF_COUNTER, 16'h0789);
        i_cap_pin_model.pulse(8);
        rc(OFF_COMPARE, 16'h0456);
        tick(12);
        rc(OFF_COMPARE, 16'h0789);
        wr(OFF_STATUS, 16'h0000);
        pin("irq", 1'b0);
        wr(OFF_EVENT_GEN, 16'h0002);
        pin("irq", 1'b1);
    endtask
    initial begin
        bus_req = '0;
        nrst = 1'b0;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        tick(3);
        t_up();
        t_down();
        t_center();
        t_upd_dis();
        t_modes();
        t_force_evt();
        t_capture();
        print_verdict();
    end
endmodule
